/* pkg/lccs_cfg.svh */
`ifndef LCCS_CFG_SVH
`define LCCS_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LCCS_REG_LUT01   5'h00
`define LCCS_REG_LUT23   5'h04
`define LCCS_REG_CELL    5'h08
`define LCCS_REG_CHAIN   5'h0C
`define LCCS_REG_PIN     5'h10
`define LCCS_REG_STAT    5'h14

// ----------------------------------------
// Field positions
// ----------------------------------------
`define LCCS_LUT_W       16
`define LCCS_CELL_STRIDE 8
`define LCCS_CELL_DSEL   0
`define LCCS_CELL_LATCH  1
`define LCCS_CELL_CKINV  2
`define LCCS_CELL_PERMEN 3
`define LCCS_CELL_GEN    4
`define LCCS_CELL_XOR    6
`define LCCS_CHAIN_EXT   0
`define LCCS_CHAIN_CONST 1
`define LCCS_CHAIN_CLRC  2
`define LCCS_PIN_STRIDE  8
`define LCCS_PIN_IINV    0
`define LCCS_PIN_OINV    1
`define LCCS_PIN_EINV    2
`define LCCS_PIN_BYP     3
`define LCCS_PIN_FAST    4
`define LCCS_STAT_Q      0
`define LCCS_STAT_CO     4
`define LCCS_STAT_COMB   8
`define LCCS_STAT_PIN    16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define LCCS_LUT_RST     32'h0000_0000
`define LCCS_CELL_RST    32'h0000_0000
`define LCCS_CHAIN_RST   32'h0000_0004
`define LCCS_PIN_RST     32'h0000_0000

`endif

/* pkg/lccs_pkg.sv */
package lccs_pkg;
  typedef logic [31:0] lccs_word_t;
  typedef enum logic {ST_FF, ST_LATCH} lccs_st_mode_t;
  typedef enum logic [1:0] {GEN_ZERO, GEN_ONE, GEN_DIRECT, GEN_OPERAND} lccs_gen_t;
endpackage

/* hdl/lccs_store.sv */
module lccs_store (
  // Clock and clears
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   clr,
  // Sampled storage clock
  input  wire logic                   ck_now,
  input  wire logic                   ck_prev,
  // Control and data
  input  wire logic                   ce,
  input  wire lccs_pkg::lccs_st_mode_t mode,
  input  wire logic                   ck_inv,
  input  wire logic                   d,
  // Stored value
  output logic                        q
);
  import lccs_pkg::*;

  logic q_r;
  wire  act_edge;
  wire  transp;
  wire  load;

  assign act_edge = ck_inv ? (ck_prev & ~ck_now) : (~ck_prev & ck_now);
  assign transp   = ck_inv ? ck_now : ~ck_now;
  assign load     = ce & ((mode == ST_FF) ? act_edge : transp);
  assign q        = q_r;

  // Clear beats clock, enable and data
  always_ff @(posedge clk or posedge rst or posedge clr) begin
    if (rst || clr) begin
      q_r <= 1'b0;
    end else if (load) begin
      q_r <= d;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_ff_edge;
    (mode == ST_FF) && ce && act_edge;
  endsequence

  AST_FF_CAPTURE:
    assert property (@(posedge clk) disable iff (rst || clr)
      s_ff_edge |=> (q == $past(d)))
    else $error("storage missed data on active edge");

  AST_HOLD_NO_CE:
    assert property (@(posedge clk) disable iff (rst || clr)
      !ce |=> $stable(q))
    else $error("storage changed with enable low");

  AST_LATCH_OPAQUE:
    assert property (@(posedge clk) disable iff (rst || clr)
      (mode == ST_LATCH) && (ck_now ^ ck_inv) |=> $stable(q))
    else $error("latch changed in opaque phase");

  AST_FF_NO_EDGE:
    assert property (@(posedge clk) disable iff (rst || clr)
      (mode == ST_FF) && (ck_now == ck_prev) |=> $stable(q))
    else $error("flip-flop changed without an edge");

  AST_CLEAR_ZERO:
    assert property (@(posedge clk) disable iff (rst)
      clr |-> (q == 1'b0))
    else $error("clear did not force zero");
endmodule

/* hdl/lccs_top.sv */
// How it works
// - Each cell has a 2:1 carry mux
// - Half-sum XOR carry gives sum bit
// - Chain starter cell feeds lowest carry
// - Top carry out feeds block above
// - Carry chain cascades wide AND/OR decode
// - Clear, reset force storage outputs zero
// - Flip-flop captures data on active edge
// - Latch follows data while clock low, or high if its clock is inverted
// - Shared enable low makes elements hold, except permanently enabled ones
// - Unconnected enable means always enabled
// - Storage data from LUT or direct
// - Four direct input to output bypasses
// - Combinational output always LUT driven
// - Shared clock, enable; optional permanent enable
// - Per-element clock polarity selection
// - Pin cell three-state, invertible out, enable
// - Pin input path invertible
// - Pin cells hold no storage elements
// - Single input delay tap, default inserted
// - Two slew modes per pin
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`include "lccs_cfg.svh"

module lccs_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Register bus
  input  wire logic [4:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire lccs_pkg::lccs_word_t avs_writedata,
  output lccs_pkg::lccs_word_t      avs_readdata,
  output logic                      avs_waitrequest,
  // Logic cell inputs
  input  wire logic [15:0]          cell_lut_in,
  input  wire logic [3:0]           direct_input,
  input  wire logic                 carry_in,
  input  wire logic                 clock_enable,
  // Storage clock and clear
  input  wire logic                 storage_clock,
  input  wire logic                 async_clear_input,
  // Logic cell outputs
  output logic [3:0]                comb_out,
  output logic [3:0]                store_q,
  output logic [3:0]                direct_out,
  output logic                      carry_out,
  // Pin cells, pad side
  input  wire logic [3:0]           pin_in,
  output logic [3:0]                pin_out,
  output logic [3:0]                pin_oe,
  output logic [3:0]                pin_fast_slew,
  // Pin cells, core side
  input  wire logic [3:0]           core_pin_data,
  input  wire logic [3:0]           core_pin_oe,
  output logic [3:0]                pin_to_core
);
  import lccs_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  lccs_word_t  lut01_r;
  lccs_word_t  lut23_r;
  lccs_word_t  cell_r;
  lccs_word_t  chain_r;
  lccs_word_t  pin_r;
  lccs_word_t  rdata_r;
  logic        ack_r;
  logic        waitreq_r;
  logic        ck_s1_r;
  logic        ck_s2_r;
  logic        ck_s3_r;
  logic [3:0]  pin_s1_r;
  logic [3:0]  pin_s2_r;
  logic [3:0]  pin_dly_r;
  logic [3:0]  pin_core_r;
  logic [3:0]  pin_out_r;
  logic [3:0]  pin_oe_r;
  logic [3:0]  comb_r;
  logic [3:0]  direct_r;
  logic        carry_r;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire         req;
  wire         take;
  wire         ack_nxt;
  wire [31:0]  be_mask;
  wire         sel_lut01;
  wire         sel_lut23;
  wire         sel_cell;
  wire         sel_chain;
  wire         sel_pin;
  wire         sel_stat;
  lccs_word_t  stat_w;
  lccs_word_t  rdata_nxt;

  function automatic lccs_word_t merge(input lccs_word_t old_v, input lccs_word_t new_v,
                                       input lccs_word_t m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  assign req       = avs_read | avs_write;
  assign take      = req & ack_r;
  // One wait cycle, then the answer stands for a single edge
  assign ack_nxt   = req & ~ack_r;
  assign be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign sel_lut01 = (avs_address == `LCCS_REG_LUT01);
  assign sel_lut23 = (avs_address == `LCCS_REG_LUT23);
  assign sel_cell  = (avs_address == `LCCS_REG_CELL);
  assign sel_chain = (avs_address == `LCCS_REG_CHAIN);
  assign sel_pin   = (avs_address == `LCCS_REG_PIN);
  assign sel_stat  = (avs_address == `LCCS_REG_STAT);

  assign stat_w = {12'h000, pin_core_r, 4'h0, comb_r, 3'h0, carry_r, store_q};

  // Unmapped addresses read zero and ignore writes
  assign rdata_nxt = sel_lut01 ? lut01_r :
                     sel_lut23 ? lut23_r :
                     sel_cell  ? cell_r  :
                     sel_chain ? chain_r :
                     sel_pin   ? pin_r   :
                     sel_stat  ? stat_w  : 32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r     <= 1'b0;
      waitreq_r <= 1'b1;
      rdata_r   <= 32'h0000_0000;
    end else begin
      ack_r     <= ack_nxt;
      waitreq_r <= ~ack_nxt;
      if (ack_nxt && avs_read) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lut01_r <= `LCCS_LUT_RST;
      lut23_r <= `LCCS_LUT_RST;
      cell_r  <= `LCCS_CELL_RST;
      chain_r <= `LCCS_CHAIN_RST;
      pin_r   <= `LCCS_PIN_RST;
    end else if (take && avs_write) begin
      if (sel_lut01) lut01_r <= merge(lut01_r, avs_writedata, be_mask);
      if (sel_lut23) lut23_r <= merge(lut23_r, avs_writedata, be_mask);
      if (sel_cell)  cell_r  <= merge(cell_r,  avs_writedata, be_mask);
      if (sel_chain) chain_r <= merge(chain_r, avs_writedata, be_mask);
      if (sel_pin)   pin_r   <= merge(pin_r,   avs_writedata, be_mask);
    end
  end

  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = waitreq_r;

  // ----------------------------------------
  // Carry chain and lookup tables
  // ----------------------------------------
  wire [63:0]  lut_all;
  wire         chain_start;
  logic [3:0]  lut_o;
  logic [4:0]  chain;
  logic [3:0]  comb_nxt;

  assign lut_all     = {lut23_r, lut01_r};
  // Starter cell: external carry or a fixed level
  assign chain_start = chain_r[`LCCS_CHAIN_EXT] ? carry_in
                                                : chain_r[`LCCS_CHAIN_CONST];

  always_comb begin
    logic [15:0] lut_v;
    logic [3:0]  sel_v;
    logic        gen_v;
    lut_v    = 16'h0000;
    sel_v    = 4'h0;
    gen_v    = 1'b0;
    lut_o    = 4'h0;
    comb_nxt = 4'h0;
    chain    = 5'h00;
    chain[0] = chain_start;
    for (int i = 0; i < 4; i++) begin
      lut_v    = lut_all[16*i +: 16];
      sel_v    = cell_lut_in[4*i +: 4];
      lut_o[i] = lut_v[sel_v];
      unique case (lccs_gen_t'(cell_r[`LCCS_CELL_STRIDE*i+`LCCS_CELL_GEN +: 2]))
        GEN_ZERO:    gen_v = 1'b0;
        GEN_ONE:     gen_v = 1'b1;
        GEN_DIRECT:  gen_v = direct_input[i];
        GEN_OPERAND: gen_v = sel_v[0];
      endcase
      // LUT high propagates the carry, low injects the generate level
      chain[i+1] = lut_o[i] ? chain[i] : gen_v;
      // Sum cell: half-sum XOR incoming carry
      comb_nxt[i] = lut_o[i] ^ (cell_r[`LCCS_CELL_STRIDE*i+`LCCS_CELL_XOR] & chain[i]);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comb_r   <= 4'h0;
      direct_r <= 4'h0;
      carry_r  <= 1'b0;
    end else begin
      comb_r   <= comb_nxt;
      direct_r <= direct_input;
      carry_r  <= chain[4];
    end
  end

  assign comb_out   = comb_r;
  assign direct_out = direct_r;
  assign carry_out  = carry_r;

  // ----------------------------------------
  // Storage elements
  // ----------------------------------------
  // Clock pin is sampled, so flip-flop and latch timing lag it by the synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
    end else begin
      ck_s1_r <= storage_clock;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
    end
  end

  wire        st_clr;
  wire [3:0]  st_q;

  // Clear left unconnected reads as low
  assign st_clr = async_clear_input & chain_r[`LCCS_CHAIN_CLRC];

  for (genvar g = 0; g < 4; g++) begin : g_store
    wire [7:0] cfg;
    wire       ce_eff;
    wire       d_sel;
    assign cfg    = cell_r[`LCCS_CELL_STRIDE*g +: 8];
    assign ce_eff = clock_enable | cfg[`LCCS_CELL_PERMEN];
    assign d_sel  = cfg[`LCCS_CELL_DSEL] ? direct_input[g] : lut_o[g];
    lccs_store u_store (
      .clk     (clk),
      .rst     (rst),
      .clr     (st_clr),
      .ck_now  (ck_s2_r),
      .ck_prev (ck_s3_r),
      .ce      (ce_eff),
      .mode    (lccs_st_mode_t'(cfg[`LCCS_CELL_LATCH])),
      .ck_inv  (cfg[`LCCS_CELL_CKINV]),
      .d       (d_sel),
      .q       (st_q[g])
    );
  end

  assign store_q = st_q;

  // ----------------------------------------
  // Pin cells
  // ----------------------------------------
  logic [3:0] iinv;
  logic [3:0] oinv;
  logic [3:0] einv;
  logic [3:0] byp;
  logic [3:0] fast;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      iinv[i] = pin_r[`LCCS_PIN_STRIDE*i+`LCCS_PIN_IINV];
      oinv[i] = pin_r[`LCCS_PIN_STRIDE*i+`LCCS_PIN_OINV];
      einv[i] = pin_r[`LCCS_PIN_STRIDE*i+`LCCS_PIN_EINV];
      byp[i]  = pin_r[`LCCS_PIN_STRIDE*i+`LCCS_PIN_BYP];
      fast[i] = pin_r[`LCCS_PIN_STRIDE*i+`LCCS_PIN_FAST];
    end
  end

  wire [3:0] pin_core_nxt;

  // Delay tap defaults to inserted; bypass is the opt-in
  assign pin_core_nxt = ((byp & pin_s2_r) | (~byp & pin_dly_r)) ^ iinv;

  // Only sampling, the delay tap and output registers: no user storage in the pin path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r   <= 4'h0;
      pin_s2_r   <= 4'h0;
      pin_dly_r  <= 4'h0;
      pin_core_r <= 4'h0;
      pin_out_r  <= 4'h0;
      pin_oe_r   <= 4'h0;
    end else begin
      pin_s1_r   <= pin_in;
      pin_s2_r   <= pin_s1_r;
      pin_dly_r  <= pin_s2_r;
      pin_core_r <= pin_core_nxt;
      pin_out_r  <= core_pin_data ^ oinv;
      pin_oe_r   <= core_pin_oe ^ einv;
    end
  end

  logic [3:0] pin_fast_r;

  assign pin_to_core   = pin_core_r;
  assign pin_out       = pin_out_r;
  assign pin_oe        = pin_oe_r;
  assign pin_fast_slew = pin_fast_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_fast_r <= 4'h0;
    end else begin
      pin_fast_r <= fast;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cfg_still;
    $stable(pin_r) ##1 $stable(pin_r) ##1 $stable(pin_r) ##1 $stable(pin_r);
  endsequence

  AST_AND_CASCADE:
    assert property (@(posedge clk) disable iff (rst)
      (cell_r[5:4] == 2'b00) && (cell_r[13:12] == 2'b00) && (cell_r[21:20] == 2'b00)
      && (cell_r[29:28] == 2'b00) && !(&lut_o) |=> !carry_out)
    else $error("AND cascade asserted with a zero bit");

  AST_CARRY_RIPPLE:
    assert property (@(posedge clk) disable iff (rst)
      (&lut_o) |=> (carry_out == $past(chain_start)))
    else $error("carry did not ripple through four cells");

  AST_BYPASS:
    assert property (@(posedge clk) disable iff (rst)
      ##1 (direct_out == $past(direct_input)))
    else $error("bypass path did not follow direct input");

  AST_PIN_DELAY:
    assert property (@(posedge clk) disable iff (rst)
      s_cfg_still ##0 (byp == 4'h0)
      |-> (pin_to_core == ($past(pin_in, 4) ^ iinv)))
    else $error("inserted pin delay is not one tap");

  AST_PIN_ENABLE:
    assert property (@(posedge clk) disable iff (rst)
      ##1 (pin_oe == ($past(core_pin_oe) ^ $past(einv))))
    else $error("pin enable path wrong");

  AST_BUS_ANSWER:
    assert property (@(posedge clk) disable iff (rst)
      req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

/* tb/lccs_top_tb_top.sv */
module lccs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import lccs_pkg::*;

  logic        clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  lccs_word_t  avs_writedata, avs_readdata, r, x, d, cfg;
  logic [15:0] cell_lut_in, v;
  logic [3:0]  direct_input, comb_out, store_q, direct_out, pin_in, pin_out, pin_oe;
  logic [3:0]  pin_fast_slew, core_pin_data, core_pin_oe, pin_to_core, a, b, eo, ee, ef, ei;
  logic        carry_in, clock_enable, storage_clock, async_clear_input, carry_out, c;
  logic [63:0] lt;
  logic [4:0]  e;
  int          mismatches, check_count;

  // Arithmetic modes: adder, AND cascade, OR cascade, pass-through, direct generate
  lccs_word_t  cellv[5] = '{32'h70707070, 32'h0, 32'h10101010, 32'h0, 32'h20202020};
  lccs_word_t  lutv[5]  = '{32'h66666666, 32'hAAAAAAAA, 32'h55555555, 32'hFFFFFFFF,
                            32'hAAAAAAAA};
  lccs_word_t  chv[5]   = '{32'h5, 32'h6, 32'h4, 32'h5, 32'h5};
  // Storage steps: data, clock pin, enable, expected outputs
  logic [3:0]  sd[9] = '{4'hF, 4'hC, 4'h0, 4'h0, 4'hF, 4'h0, 4'h0, 4'hF, 4'hF};
  logic        sk[9] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0};
  logic        se[9] = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1};
  logic [3:0]  sq[9] = '{4'h1, 4'hD, 4'hD, 4'h5, 4'h1, 4'h0, 4'h0, 4'h2, 4'h3};
  logic [4:0]  ra[7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h18, 5'h01};
  lccs_word_t  rv[7] = '{32'h0, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0, 32'h0};

  lccs_top u_dut (
    .clk, .rst, .avs_address, .avs_read, .avs_write, .avs_byteenable, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .cell_lut_in, .direct_input, .carry_in,
    .clock_enable, .storage_clock, .async_clear_input, .comb_out, .store_q, .direct_out,
    .carry_out, .pin_in, .pin_out, .pin_oe, .pin_fast_slew, .core_pin_data, .core_pin_oe,
    .pin_to_core
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input lccs_word_t s, input lccs_word_t xp);
    check_count++;
    if (s !== xp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", n, xp, s);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic wr, input logic [4:0] ad, input lccs_word_t wd,
                      input logic [3:0] be, output lccs_word_t rd);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= wd;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] ad, input lccs_word_t wd);
    xfer(1'b1, ad, wd, 4'hF, r);
  endtask

  function automatic logic [4:0] model(input int m, input logic [3:0] aa,
                                       input logic [3:0] bb, input logic ci);
    logic cc;
    cc = ci;
    case (m)
      0: return 5'(aa) + 5'(bb) + 5'(ci);
      1: return {&aa, 4'h0};
      2: return {|aa, 4'h0};
      4: begin
        // Propagate where the select bit is one, else take the direct level
        for (int j = 0; j < 4; j++)
          cc = aa[j] ? cc : bb[j];
        return {cc, 4'h0};
      end
      default: return {ci, 4'h0};
    endcase
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {avs_address, avs_read, avs_write, avs_byteenable, avs_writedata} = '0;
    {cell_lut_in, direct_input, carry_in, clock_enable, storage_clock} = '0;
    {async_clear_input, pin_in, core_pin_data, core_pin_oe} = '0;
    rst = 1'b1;
    void'($urandom(56));
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    chk("waitrequest", avs_waitrequest, 32'h1);
    chk("store_q_rst", store_q, 32'h0);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, ra[i], 32'h0, 4'h0, x);
      chk("reg_rst", x, rv[i]);
    end
    wr(5'h14, 32'hFFFFFFFF);
    wr(5'h1C, 32'hFFFFFFFF);
    xfer(1'b0, 5'h14, 32'h0, 4'h0, x);
    chk("stat_ro", x, 32'h0);
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      v[3:0] = $urandom;
      xfer(1'b0, ra[i % 2], 32'h0, 4'h0, r);
      xfer(1'b1, ra[i % 2], d, v[3:0], x);
      xfer(1'b0, ra[i % 2], 32'h0, 4'h0, x);
      cfg = {{8{v[3]}}, {8{v[2]}}, {8{v[1]}}, {8{v[0]}}};
      chk("lut_bytes", x, (r & ~cfg) | (d & cfg));
    end
    $display("test registers done");

    lt = {$urandom, $urandom};
    wr(5'h00, lt[31:0]);
    wr(5'h04, lt[63:32]);
    for (int i = 0; i < 12; i++) begin
      v = $urandom;
      a = $urandom;
      @(posedge clk);
      cell_lut_in <= v;
      direct_input <= a;
      cyc(2);
      for (int j = 0; j < 4; j++)
        eo[j] = lt[16 * j + v[4 * j +: 4]];
      chk("comb_out", comb_out, eo);
      chk("direct_out", direct_out, a);
    end
    $display("test combinational done");

    for (int m = 0; m < 5; m++) begin
      wr(5'h08, cellv[m]);
      wr(5'h00, lutv[m]);
      wr(5'h04, lutv[m]);
      wr(5'h0C, chv[m]);
      for (int i = 0; i < 10; i++) begin
        {a, b, c} = 9'($urandom);
        for (int j = 0; j < 4; j++)
          v[4 * j +: 4] = {2'b00, b[j], a[j]};
        @(posedge clk);
        cell_lut_in <= v;
        carry_in <= c;
        direct_input <= b;
        cyc(2);
        e = model(m, a, b, c);
        chk("carry_out", carry_out, e[4]);
        if (m == 0)
          chk("sum", comb_out, e[3:0]);
      end
    end
    $display("test carry done");

    // Cell1 stores its all-zero LUT result, cell3 ignores the enable
    wr(5'h00, 32'h0);
    wr(5'h08, 32'h0D050001);
    for (int i = 0; i < 9; i++) begin
      if (i == 4) begin
        @(posedge clk);
        async_clear_input <= 1'b1;
        #1;
        chk("clear", store_q, 32'h0);
        @(posedge clk);
        async_clear_input <= 1'b0;
        wr(5'h08, 32'h01010703);
      end
      @(posedge clk);
      direct_input <= sd[i];
      storage_clock <= sk[i];
      clock_enable <= se[i];
      cyc(8);
      chk("store_q", store_q, sq[i]);
    end
    // Clear left unconnected must not disturb the stored values
    wr(5'h0C, 32'h0);
    @(posedge clk);
    async_clear_input <= 1'b1;
    cyc(2);
    chk("clear_open", store_q, 32'h3);
    async_clear_input <= 1'b0;
    $display("test storage done");

    for (int i = 0; i < 8; i++) begin
      cfg = $urandom & 32'h1F1F1F1F;
      wr(5'h10, cfg);
      {a, b, c} = 9'($urandom);
      d = $urandom;
      v[3:0] = pin_in;
      @(posedge clk);
      core_pin_data <= a;
      core_pin_oe <= b;
      pin_in <= d[3:0];
      cyc(4);
      // Bypassed pins arrive one clock ahead of delayed ones
      for (int j = 0; j < 4; j++)
        ei[j] = (cfg[8 * j + 3] ? d[j] : v[j]) ^ cfg[8 * j];
      chk("pin_tap", pin_to_core, ei);
      cyc(4);
      for (int j = 0; j < 4; j++) begin
        eo[j] = a[j] ^ cfg[8 * j + 1];
        ee[j] = b[j] ^ cfg[8 * j + 2];
        ef[j] = cfg[8 * j + 4];
        ei[j] = d[j] ^ cfg[8 * j];
      end
      chk("pin_out", pin_out, eo);
      chk("pin_oe", pin_oe, ee);
      chk("pin_fast_slew", pin_fast_slew, ef);
      chk("pin_to_core", pin_to_core, ei);
      xfer(1'b0, 5'h14, 32'h0, 4'h0, x);
      chk("stat_pin", x[19:16], ei);
    end
    $display("test pins done");
    test_done();
  end

  // Whole run is under six hundred cycles; this leaves ample margin
  initial begin
    #100000;
    mismatches++;
    $display("watchdog expired");
    test_done();
  end
endmodule
